// *** rtl/dio_top.sv ***
`timescale 1ns/1ps
`include "dio_params.svh"

module dio_top #(
    parameter int STROBE_CYC = `DIO_STROBE_CYC,
    parameter int TRIGGER_FOLLOW_OUT_CYC  = `DIO_TRIGGER_FOLLOW_OUT_EXT_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [7:0]  gp_output_bits,
    input  wire logic        fixed_input_bit_two,
    input  wire logic        fixed_input_bit_three,
    input  wire logic        dual_input_zero_or_ext_clock,
    input  wire logic        dual_input_one_or_trigger,
    output logic             output_latch_strobe,
    output logic             trigger_follow_out,
    output logic             conv_start,
    output logic             acq_running
);

    localparam int EXT_DLY = TRIGGER_FOLLOW_OUT_CYC - `DIO_SYNC_LAT;

    // Both counts live in 8-bit counters
    if (EXT_DLY < 1 || TRIGGER_FOLLOW_OUT_CYC > 255 || STROBE_CYC > 255) begin : g_chk
        $error("dio_top: TRIGGER_FOLLOW_OUT_CYC or STROBE_CYC out of range");
    end

    function automatic logic edge_seen(input logic cur, input logic prev,
                                       input logic falling);
        edge_seen = falling ? (prev & ~cur) : (cur & ~prev);
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Pin synchronisers; reset to one so idle lines match the pull-ups
    logic [3:0] pin_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] prev_q;

    assign pin_raw = {fixed_input_bit_three, fixed_input_bit_two,
                      dual_input_one_or_trigger, dual_input_zero_or_ext_clock};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= `DIO_PIN_RST;
            sync2_q <= `DIO_PIN_RST;
            prev_q  <= `DIO_PIN_RST;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Configuration
    logic                    clk_sel_q;
    dio_pkg::line1_mode_type l1_mode_q;
    logic                    edge_fall_q;
    logic                    int_pacer_q;
    dio_pkg::acq_mode_type   acq_mode_q;
    logic [15:0]             div_q;
    logic                    cfg_wr;
    logic                    ctrl_wr;
    logic                    out_wr;

    assign cfg_wr  = reg_wr && hit(reg_addr, `DIO_OFS_CFG);
    assign ctrl_wr = reg_wr && hit(reg_addr, `DIO_OFS_CTRL);
    assign out_wr  = reg_wr && hit(reg_addr, `DIO_OFS_OUT);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sel_q   <= 1'b0;
            l1_mode_q   <= dio_pkg::L1_PLAIN;
            edge_fall_q <= 1'b0;
            int_pacer_q <= 1'b0;
            acq_mode_q  <= dio_pkg::ACQ_POST;
        end else if (cfg_wr) begin
            clk_sel_q   <= reg_wdata[`DIO_CFG_CLK_SEL];
            case (reg_wdata[`DIO_CFG_L1_LSB +: 2])
                2'h1:    l1_mode_q <= dio_pkg::L1_TRIGGER;
                2'h2:    l1_mode_q <= dio_pkg::L1_GATE;
                default: l1_mode_q <= dio_pkg::L1_PLAIN;
            endcase
            edge_fall_q <= reg_wdata[`DIO_CFG_EDGE_FALL];
            // External clock wins when both sources are requested
            int_pacer_q <= reg_wdata[`DIO_CFG_INT_PACER]
                           & ~reg_wdata[`DIO_CFG_CLK_SEL];
            case (reg_wdata[`DIO_CFG_ACQ_LSB +: 2])
                2'h1:    acq_mode_q <= dio_pkg::ACQ_PRE;
                2'h2:    acq_mode_q <= dio_pkg::ACQ_ABOUT;
                default: acq_mode_q <= dio_pkg::ACQ_POST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= `DIO_DIV_RST;
        end else if (reg_wr && hit(reg_addr, `DIO_OFS_DIV)) begin
            div_q <= reg_wdata[15:0];
        end
    end

    // Output word and strobe
    logic [7:0] out_q;
    logic       strobe_busy;
    logic       out_take;
    logic       ovr_q;

    // Writes during a strobe are refused so no pulse is lost or shared
    assign out_take = out_wr && !strobe_busy;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= `DIO_OUT_RST;
        end else if (out_take) begin
            out_q <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_q <= 1'b0;
        end else if (out_wr && strobe_busy) begin
            ovr_q <= 1'b1;
        end else if (ctrl_wr && reg_wdata[`DIO_CTRL_OVR_CLR]) begin
            ovr_q <= 1'b0;
        end
    end

    strobe_pulse_gen #(
        .HIGH_CYC (STROBE_CYC)
    ) u_strobe (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (out_take),
        .pulse  (output_latch_strobe),
        .busy   (strobe_busy)
    );

    assign gp_output_bits = out_q;

    // Acquisition control
    dio_pkg::acq_state_type acq_q;
    dio_pkg::acq_state_type acq_d;
    logic sw_start;
    logic sw_stop;
    logic ext_trig;
    logic gate_lvl;
    logic start_ext;
    logic start_int;

    assign sw_start = ctrl_wr && reg_wdata[`DIO_CTRL_START];
    assign sw_stop  = ctrl_wr && reg_wdata[`DIO_CTRL_STOP];
    assign ext_trig = (l1_mode_q == dio_pkg::L1_TRIGGER)
                      && edge_seen(sync2_q[1], prev_q[1], edge_fall_q);
    assign gate_lvl = (l1_mode_q == dio_pkg::L1_GATE) && sync2_q[1];

    always_comb begin
        acq_d = acq_q;
        case (acq_q)
            dio_pkg::ST_IDLE: begin
                if (sw_start) begin
                    if ((l1_mode_q == dio_pkg::L1_TRIGGER && acq_mode_q == dio_pkg::ACQ_POST)
                        || l1_mode_q == dio_pkg::L1_GATE) begin
                        acq_d = dio_pkg::ST_ARMED;
                    end else begin
                        acq_d = dio_pkg::ST_RUN;
                    end
                end
            end
            dio_pkg::ST_ARMED: begin
                if (sw_stop) begin
                    acq_d = dio_pkg::ST_IDLE;
                end else if (ext_trig || gate_lvl) begin
                    acq_d = dio_pkg::ST_RUN;
                end
            end
            dio_pkg::ST_RUN: begin
                if (sw_stop) begin
                    acq_d = dio_pkg::ST_IDLE;
                end else if (l1_mode_q == dio_pkg::L1_GATE && !sync2_q[1]) begin
                    acq_d = dio_pkg::ST_ARMED;
                end else if (acq_mode_q == dio_pkg::ACQ_PRE && ext_trig) begin
                    acq_d = dio_pkg::ST_IDLE;
                end
            end
            default: acq_d = dio_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acq_q <= dio_pkg::ST_IDLE;
        end else begin
            acq_q <= acq_d;
        end
    end

    assign start_ext = (acq_q == dio_pkg::ST_ARMED) && (acq_d == dio_pkg::ST_RUN);
    assign start_int = (acq_q == dio_pkg::ST_IDLE) && (acq_d == dio_pkg::ST_RUN);
    assign acq_running = (acq_q == dio_pkg::ST_RUN);

    // Trigger-out delay; the synchroniser latency is taken off the count
    logic [7:0] dly_q;
    logic       trigger_follow_out_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_q <= 8'h00;
        end else if (acq_d != dio_pkg::ST_RUN) begin
            dly_q <= 8'h00;
        end else if (start_ext) begin
            dly_q <= 8'(EXT_DLY);
        end else if (start_int) begin
            dly_q <= 8'h01;
        end else if (dly_q != 8'h00) begin
            dly_q <= dly_q - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trigger_follow_out_q <= 1'b0;
        end else if (acq_d != dio_pkg::ST_RUN || acq_mode_q == dio_pkg::ACQ_ABOUT) begin
            trigger_follow_out_q <= 1'b0;
        end else if (dly_q == 8'h01) begin
            trigger_follow_out_q <= 1'b1;
        end
    end

    assign trigger_follow_out = trigger_follow_out_q;

    // Pacer and conversion start
    logic [15:0] pacer_q;
    logic        tick_int;
    logic        tick_ext;
    logic        conv_q;
    logic [15:0] conv_cnt_q;

    assign tick_int = acq_running && int_pacer_q && (pacer_q == 16'h0000);
    assign tick_ext = acq_running && clk_sel_q
                      && edge_seen(sync2_q[0], prev_q[0], 1'b0);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pacer_q <= 16'h0000;
        end else if (!acq_running || pacer_q == 16'h0000) begin
            pacer_q <= div_q;
        end else begin
            pacer_q <= pacer_q - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_q <= 1'b0;
        end else begin
            // Software start coexists with either hardware source
            conv_q <= tick_int || tick_ext
                      || (ctrl_wr && reg_wdata[`DIO_CTRL_CONV]);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_cnt_q <= 16'h0000;
        end else if (reg_wr && hit(reg_addr, `DIO_OFS_CNT)) begin
            conv_cnt_q <= 16'h0000;
        end else if (conv_q) begin
            conv_cnt_q <= conv_cnt_q + 16'h0001;
        end
    end

    assign conv_start = conv_q;

    // Register read
    logic [3:0]  in_view;
    logic [31:0] rd_d;
    logic [31:0] rdata_q;

    assign in_view = {sync2_q[3], sync2_q[2],
                      sync2_q[1] & (l1_mode_q == dio_pkg::L1_PLAIN),
                      sync2_q[0] & ~clk_sel_q};

    always_comb begin
        rd_d = 32'h0000_0000;
        case (reg_addr)
            `DIO_OFS_OUT:  rd_d[7:0]  = out_q;
            `DIO_OFS_CFG:  rd_d[6:0]  = {acq_mode_q, int_pacer_q, edge_fall_q,
                                         l1_mode_q, clk_sel_q};
            `DIO_OFS_IN:   rd_d[3:0]  = in_view;
            `DIO_OFS_STAT: rd_d[4:0]  = {ovr_q, strobe_busy, trigger_follow_out_q, acq_q};
            `DIO_OFS_DIV:  rd_d[15:0] = div_q;
            `DIO_OFS_CNT:  rd_d[15:0] = conv_cnt_q;
            default:       rd_d       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // Strobe length seen so far, so the width check needs no long repetition
    logic [7:0] strobe_len_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            strobe_len_q <= 8'h00;
        end else if (output_latch_strobe) begin
            strobe_len_q <= strobe_len_q + 8'h01;
        end else begin
            strobe_len_q <= 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    strobe_width_a: assert property (
        $fell(output_latch_strobe) |-> strobe_len_q == 8'(STROBE_CYC))
        else $error("strobe width differs from the set length");

    output_stable_a: assert property (
        $changed(gp_output_bits) |-> $rose(output_latch_strobe))
        else $error("output word changed without a strobe");

    strobe_per_write_a: assert property (
        out_take |=> $rose(output_latch_strobe) && strobe_busy)
        else $error("accepted write gave no strobe");

    strobe_cause_a: assert property (
        $rose(output_latch_strobe) |-> $past(out_take))
        else $error("strobe without an accepted write");

    trigger_follow_out_ext_a: assert property (
        (start_ext && acq_mode_q != dio_pkg::ACQ_ABOUT) ##1
        (acq_q == dio_pkg::ST_RUN && acq_mode_q != dio_pkg::ACQ_ABOUT) [*6]
        |-> trigger_follow_out)
        else $error("trigger-out late after external start");

    trigger_follow_out_early_a: assert property (
        start_ext |=> !trigger_follow_out [*5])
        else $error("trigger-out early after external start");

    trigger_follow_out_int_a: assert property (
        (start_int && acq_mode_q != dio_pkg::ACQ_ABOUT) ##1
        (acq_q == dio_pkg::ST_RUN && acq_mode_q != dio_pkg::ACQ_ABOUT) [*2]
        |-> trigger_follow_out)
        else $error("trigger-out late after internal start");

    trigger_follow_out_follow_a: assert property (
        trigger_follow_out |-> acq_q == dio_pkg::ST_RUN)
        else $error("trigger-out high outside acquisition");

    trigger_follow_out_about_a: assert property (
        acq_mode_q == dio_pkg::ACQ_ABOUT ##1 acq_mode_q == dio_pkg::ACQ_ABOUT
        |-> !trigger_follow_out)
        else $error("trigger-out in about-trigger mode");

    pacer_excl_a: assert property (
        !(int_pacer_q && clk_sel_q) && !(tick_int && tick_ext))
        else $error("both pacer sources active");

    line0_mask_a: assert property (
        (reg_rd && hit(reg_addr, `DIO_OFS_IN) && clk_sel_q) |=> reg_rdata[0] == 1'b0)
        else $error("line zero readable while clock input");

    line1_mask_a: assert property (
        (reg_rd && hit(reg_addr, `DIO_OFS_IN) && l1_mode_q != dio_pkg::L1_PLAIN)
        |=> reg_rdata[1] == 1'b0)
        else $error("line one readable while trigger or gate");

    pullup_reset_a: assert property (
        $rose(arst_n) |-> sync2_q == `DIO_PIN_RST)
        else $error("inputs not high after reset");

    edge_select_a: assert property (
        (acq_q == dio_pkg::ST_ARMED && l1_mode_q == dio_pkg::L1_TRIGGER && !edge_fall_q
         && prev_q[1] && !sync2_q[1] && !sw_stop) |=> acq_q == dio_pkg::ST_ARMED)
        else $error("wrong trigger edge started acquisition");

    strobe_seen_c: cover property ($rose(output_latch_strobe));
    ext_start_c:   cover property (start_ext ##[1:20] $rose(trigger_follow_out));
    gate_drop_c:   cover property (acq_q == dio_pkg::ST_RUN ##1 acq_q == dio_pkg::ST_ARMED);
    refused_c:     cover property (out_wr && strobe_busy);

endmodule

// *** include/dio_params.svh ***
`ifndef DIO_PARAMS_SVH
`define DIO_PARAMS_SVH

`define DIO_CLK_PERIOD_NS   25
`define DIO_STROBE_NS       300
`define DIO_STROBE_CYC      ((`DIO_STROBE_NS + `DIO_CLK_PERIOD_NS - 1) / `DIO_CLK_PERIOD_NS)
`define DIO_TRIGGER_FOLLOW_OUT_EXT_NS    200
`define DIO_TRIGGER_FOLLOW_OUT_EXT_CYC   (`DIO_TRIGGER_FOLLOW_OUT_EXT_NS / `DIO_CLK_PERIOD_NS)
`define DIO_TRIGGER_FOLLOW_OUT_INT_NS    1000
`define DIO_TRIGGER_FOLLOW_OUT_INT_CYC   (`DIO_TRIGGER_FOLLOW_OUT_INT_NS / `DIO_CLK_PERIOD_NS)
`define DIO_SYNC_LAT        3

`define DIO_OFS_OUT         8'h00
`define DIO_OFS_CFG         8'h04
`define DIO_OFS_IN          8'h08
`define DIO_OFS_CTRL        8'h0C
`define DIO_OFS_STAT        8'h10
`define DIO_OFS_DIV         8'h14
`define DIO_OFS_CNT         8'h18

`define DIO_CFG_CLK_SEL     0
`define DIO_CFG_L1_LSB      1
`define DIO_CFG_EDGE_FALL   3
`define DIO_CFG_INT_PACER   4
`define DIO_CFG_ACQ_LSB     5

`define DIO_CTRL_START      0
`define DIO_CTRL_STOP       1
`define DIO_CTRL_CONV       2
`define DIO_CTRL_OVR_CLR    3

`define DIO_STAT_STATE_LSB  0
`define DIO_STAT_TRIGGER_FOLLOW_OUT      2
`define DIO_STAT_BUSY       3
`define DIO_STAT_OVR        4

`define DIO_OUT_RST         8'h00
`define DIO_DIV_RST         16'h03E8
`define DIO_PIN_RST         4'hF

`endif

// *** include/dio_pkg.sv ***
package dio_pkg;

    typedef enum logic [1:0] {
        L1_PLAIN   = 2'b00,
        L1_TRIGGER = 2'b01,
        L1_GATE    = 2'b10
    } line1_mode_type;

    typedef enum logic [1:0] {
        ACQ_POST  = 2'b00,
        ACQ_PRE   = 2'b01,
        ACQ_ABOUT = 2'b10
    } acq_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b10
    } acq_state_type;

endpackage

// *** rtl/strobe_pulse_gen.sv ***
`timescale 1ns/1ps
`include "dio_params.svh"

module strobe_pulse_gen #(
    parameter int HIGH_CYC = `DIO_STROBE_CYC
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    output logic      pulse,
    output logic      busy
);

    localparam int W = $clog2(HIGH_CYC + 2);

    if (HIGH_CYC < 1) begin : g_chk
        $error("strobe_pulse_gen: HIGH_CYC must be at least one");
    end

    logic [W-1:0] cnt_q;
    logic         pulse_q;

    // One extra low cycle keeps two pulses from merging
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (start && cnt_q == '0) begin
            cnt_q <= W'(HIGH_CYC + 1);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_q <= 1'b0;
        end else if (start && cnt_q == '0) begin
            pulse_q <= 1'b1;
        end else if (cnt_q == W'(2)) begin
            pulse_q <= 1'b0;
        end
    end

    assign pulse = pulse_q;
    assign busy  = (cnt_q != '0);

endmodule

// *** tb/ext_equipment.sv ***
`timescale 1ns/1ps

module ext_equipment (
    input  wire logic       clk,
    input  wire logic [7:0] gp_output_bits,
    input  wire logic       output_latch_strobe,
    output logic      [3:0] pins
);
    logic [7:0] latched;
    logic       armed;
    int         n_latch;
    int         hi_cycles;

    // Pins rest high, as the pull-ups leave an unconnected input
    initial begin
        pins = 4'hF;
        latched = 8'h00;
        armed = 1'b0;
        n_latch = 0;
        hi_cycles = 0;
    end

    // Armed on a real rising edge so the reset settling of the line is not taken as a latch
    always @(posedge output_latch_strobe) armed = 1'b1;

    always @(negedge output_latch_strobe) begin
        if (armed) begin
            latched = gp_output_bits;
            n_latch++;
            armed = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (output_latch_strobe === 1'b1) hi_cycles++;
    end

    task automatic set_pins(input logic [3:0] v);
        @(posedge clk);
        pins <= v;
    endtask

    // Pacer clock stands still high between bursts; each pulse is one rising edge
    task automatic clock_pulses(input int k);
        repeat (k) begin
            set_pins({pins[3:1], 1'b0});
            repeat (3) @(posedge clk);
            set_pins({pins[3:1], 1'b1});
            repeat (3) @(posedge clk);
        end
    endtask
endmodule

// *** tb/tb_digital_io_strobe_trigger_out.sv ***
`timescale 1ns/1ps

module tb_digital_io_strobe_trigger_out;
    localparam int SC = 12;
    localparam int TC = 8;
    logic        clk;
    logic        arst_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0]  gp_output_bits;
    logic [3:0]  pins;
    logic        output_latch_strobe;
    logic        trigger_follow_out;
    logic        conv_start;
    logic        acq_running;
    int          fail_count;
    int          n_checks;
    int          conv_pulses;
    int          n;

    dio_top DUT (
        .clk                          (clk),
        .arst_n                       (arst_n),
        .reg_addr                     (reg_addr),
        .reg_wdata                    (reg_wdata),
        .reg_wr                       (reg_wr),
        .reg_rd                       (reg_rd),
        .reg_rdata                    (reg_rdata),
        .gp_output_bits               (gp_output_bits),
        .fixed_input_bit_two          (pins[2]),
        .fixed_input_bit_three        (pins[3]),
        .dual_input_zero_or_ext_clock (pins[0]),
        .dual_input_one_or_trigger    (pins[1]),
        .output_latch_strobe          (output_latch_strobe),
        .trigger_follow_out           (trigger_follow_out),
        .conv_start                   (conv_start),
        .acq_running                  (acq_running)
    );

    ext_equipment u_ext (
        .clk                 (clk),
        .gp_output_bits      (gp_output_bits),
        .output_latch_strobe (output_latch_strobe),
        .pins                (pins)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_start === 1'b1) conv_pulses++;
    end

    task automatic results;
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_range(input int got, input int lo, input int hi, input string what);
        n_checks++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("unexpected at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask

    task automatic wait_tg(input logic lvl, output int c);
        c = 0;
        while (trigger_follow_out !== lvl) begin
            @(posedge clk);
            #1;
            c++;
            if (c > 100) begin
                fail_count++;
                $display("unexpected at %0t: trigger-out wait timed out", $time);
                results();
            end
        end
    endtask

    initial begin
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fail_count = 0;
        n_checks = 0;
        conv_pulses = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rchk(8'h00, 32'h0, "out reset");
        rchk(8'h14, 32'h3E8, "div reset");
        rchk(8'h10, 32'h0, "stat reset");
        rchk(8'h08, 32'hF, "idle inputs");
        wr(8'h1C, 32'hFF);
        rchk(8'h1C, 32'h0, "unmapped");
        u_ext.set_pins(4'h5);
        repeat (4) @(posedge clk);
        rchk(8'h08, 32'h5, "input pattern");
        u_ext.set_pins(4'hA);
        repeat (4) @(posedge clk);
        rchk(8'h08, 32'hA, "input pattern two");
        u_ext.set_pins(4'hF);
        wr(8'h04, 32'h11);
        rchk(8'h04, 32'h01, "pacer exclusive");
        rchk(8'h08, 32'hE, "line0 as clock");
        wr(8'h04, 32'h02);
        rchk(8'h08, 32'hD, "line1 as trigger");
        wr(8'h04, 32'h04);
        rchk(8'h08, 32'hD, "line1 as gate");
        // Strobe framing, a refused write while busy, then a second accepted word
        wr(8'h00, 32'h5A);
        #1;
        chk(gp_output_bits, 8'h5A, "out word");
        chk(output_latch_strobe, 1'b1, "strobe with data");
        wr(8'h00, 32'hA5);
        #1;
        chk(gp_output_bits, 8'h5A, "held while busy");
        repeat (14) @(posedge clk);
        chk(u_ext.latched, 8'h5A, "latched word");
        chk(u_ext.hi_cycles, SC, "strobe width");
        chk(u_ext.n_latch, 1, "one pulse");
        rchk(8'h10, 32'h10, "overrun flag");
        wr(8'h0C, 32'h8);
        wr(8'h00, 32'h33);
        repeat (14) @(posedge clk);
        chk(u_ext.latched, 8'h33, "second word");
        chk(u_ext.hi_cycles, 2 * SC, "two widths");
        chk(u_ext.n_latch, 2, "two pulses");
        rchk(8'h10, 32'h0, "flag cleared");
        // External trigger, rising then falling active edge, wrong edge first
        for (int pol = 0; pol < 2; pol++) begin
            u_ext.set_pins({2'b11, ~pol[0], 1'b1});
            wr(8'h04, 32'(2 + 8 * pol));
            wr(8'h0C, 32'h1);
            rchk(8'h10, 32'h1, "armed");
            u_ext.set_pins({2'b11, pol[0], 1'b1});
            repeat (12) @(posedge clk);
            chk(trigger_follow_out, 1'b0, "wrong edge");
            u_ext.set_pins({2'b11, ~pol[0], 1'b1});
            wait_tg(1'b1, n);
            chk_range(n, TC - 1, TC + 1, "trigger delay");
            rchk(8'h10, 32'h6, "run with trigger-out");
            wr(8'h0C, 32'h2);
            wait_tg(1'b0, n);
            chk_range(n, 0, 2, "stop drop");
        end
        // External gate
        u_ext.set_pins(4'hD);
        wr(8'h04, 32'h04);
        wr(8'h0C, 32'h1);
        rchk(8'h10, 32'h1, "gate armed");
        u_ext.set_pins(4'hF);
        wait_tg(1'b1, n);
        chk_range(n, TC - 1, TC + 1, "gate delay");
        chk(acq_running, 1'b1, "gate running");
        u_ext.set_pins(4'hD);
        wait_tg(1'b0, n);
        chk_range(n, 1, TC + 1, "gate off");
        rchk(8'h10, 32'h1, "rearmed");
        wr(8'h0C, 32'h2);
        // Internal start, then about mode
        u_ext.set_pins(4'hF);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h1);
        wait_tg(1'b1, n);
        chk_range(n, 1, 40, "internal delay");
        wr(8'h0C, 32'h2);
        wr(8'h04, 32'h40);
        wr(8'h0C, 32'h1);
        repeat (45) @(posedge clk);
        chk(acq_running, 1'b1, "about running");
        chk(trigger_follow_out, 1'b0, "about no pulse");
        wr(8'h0C, 32'h2);
        // External pacer plus a software start; a short divider exposes a leaking pacer
        wr(8'h14, 32'h4);
        wr(8'h04, 32'h11);
        wr(8'h18, 32'h0);
        wr(8'h0C, 32'h1);
        conv_pulses = 0;
        u_ext.clock_pulses(3);
        wr(8'h0C, 32'h4);
        repeat (5) @(posedge clk);
        chk(conv_pulses, 4, "conversion pulses");
        rchk(8'h18, 32'h4, "conversion count");
        wr(8'h0C, 32'h2);
        // Pre-trigger run ends on the selected edge; the falling edge first is ignored
        wr(8'h04, 32'h22);
        wr(8'h0C, 32'h1);
        wait_tg(1'b1, n);
        chk_range(n, 1, 40, "pre internal delay");
        u_ext.set_pins(4'hD);
        repeat (4) @(posedge clk);
        chk(acq_running, 1'b1, "pre wrong edge");
        u_ext.set_pins(4'hF);
        wait_tg(1'b0, n);
        chk_range(n, 2, 4, "pre trigger stop");
        rchk(8'h10, 32'h0, "pre idle");
        // Internal pacer, divider 4: a tick every fifth running cycle, ten in this run
        wr(8'h04, 32'h10);
        wr(8'h18, 32'h0);
        wr(8'h0C, 32'h1);
        repeat (50) @(posedge clk);
        wr(8'h0C, 32'h2);
        rchk(8'h18, 32'hA, "internal pacer count");
        results();
    end
endmodule
